// file: edge_detect.sv
`timescale 1ns/1ps
// Synchronises one external pin and reports selected edges
module edge_detect
  import irq_ctrl_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic i_pin,
  input wire logic [1:0] i_sel,
  output logic o_edge
);

  // Two-stage synchroniser plus history
  logic s1_q;
  logic s2_q;
  logic prev_q;
  logic rise;
  logic fall;

  // Synchroniser and history registers
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      prev_q <= 1'b0;
    end else if (i_ce) begin
      s1_q <= i_pin;
      s2_q <= s1_q;
      prev_q <= s2_q;
    end
  end

  assign rise = s2_q & ~prev_q;
  assign fall = ~s2_q & prev_q;

  // Edge type decode: off, rising, falling, both
  always_comb begin
    unique case (i_sel)
      EDGE_RISE: o_edge = rise;
      EDGE_FALL: o_edge = fall;
      EDGE_BOTH: o_edge = rise | fall;
      default: o_edge = 1'b0;
    endcase
  end

endmodule

// file: flag_cell.sv
`timescale 1ns/1ps
// One request flag: hardware set wins over software write
module flag_cell
  import irq_ctrl_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic i_set,
  input wire logic i_wr,
  input wire logic i_wval,
  output logic o_flag
);

  // Flag register
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_flag <= 1'b0;
    end else if (i_ce) begin
      if (i_set) begin
        o_flag <= 1'b1;
      end else if (i_wr) begin
        o_flag <= i_wval;
      end
    end
  end

endmodule

// file: irq_ctrl_pkg.sv
package irq_ctrl_pkg;

  // Register word offsets on the APB bus (byte addresses)
  localparam logic [7:0] OFS_EDGE_SEL = 8'h00;
  localparam logic [7:0] OFS_PRI_0 = 8'h04;
  localparam logic [7:0] OFS_PRI_1 = 8'h08;
  localparam logic [7:0] OFS_PRI_2 = 8'h0C;
  localparam logic [7:0] OFS_PRI_3 = 8'h10;
  localparam logic [7:0] OFS_MF_0 = 8'h14;
  localparam logic [7:0] OFS_MF_1 = 8'h18;
  localparam logic [7:0] OFS_MF_2 = 8'h1C;
  localparam logic [7:0] OFS_MF_3 = 8'h20;
  localparam logic [7:0] OFS_STATUS = 8'h24;

  // Reset values
  localparam logic [7:0] RST_REG = 8'h00;

  // Field positions in primary_int_ctrl_0
  localparam int POS_GLOBAL_EN = 0;

  // Edge select codes
  localparam logic [1:0] EDGE_OFF = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;

  // APB request carried as one packed group
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } apb_req_type;

  // APB access phases
  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_SETUP = 2'b01,
    PH_ACCESS = 2'b10
  } apb_phase_type;

endpackage

// file: irq_flag_ctrl.sv
// The implementer's own choices: the APB slave port and the register offsets.
`timescale 1ns/1ps
// Summary of operation
// - Pin 0 codes: off, rise, fall, both
// - Pin 1 select in bits 3..2
// - Four-pin variant: pin 2 in bits 5..4
// - Four-pin variant: pin 3 in bits 7..6
// - Two-pin variant: upper bits read zero
// - Hardware sets flags; software sets enables
// - Each source has enable and flag
// - Grouped sources report via group flag
// - One edge-select register, one field per pin
// - Up to four primary control registers
// - Timers 1..3 have period, A, B; timer 0 has period, A only
// - Bit 0 of primary 0 is global enable
// - Flags read 1 pending, software writable except the read-only group flags
module irq_flag_ctrl
  import irq_ctrl_pkg::*;
#(
  parameter int NUM_PINS = 4
)(
  input wire logic I_CORE_CLK,
  input wire logic I_RESET_N,
  input wire logic I_CE,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [7:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  input wire logic [3:0] I_EXT_PIN,
  input wire logic [1:0] I_CMP_EVT,
  input wire logic I_CONV_EVT,
  input wire logic [1:0] I_TB_EVT,
  input wire logic I_SERIAL_EVT,
  input wire logic I_LOW_VOLT_EVT,
  input wire logic I_NVMEM_EVT,
  input wire logic I_PIN_CHANGE_EVT,
  input wire logic [3:0] I_TMR_PERIOD_EVT,
  input wire logic [3:0] I_TMR_CMP_A_EVT,
  input wire logic [3:0] I_TMR_CMP_B_EVT,
  output logic O_IRQ
);

  // Reset release through two flip-flops
  logic rst_s1_q;
  logic rst_n;
  always_ff @(posedge I_CORE_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      rst_s1_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n <= rst_s1_q;
    end
  end

  // Bus request bundle
  apb_req_type req;
  assign req = '{psel: I_PSEL, penable: I_PENABLE, pwrite: I_PWRITE,
                 paddr: I_PADDR, pwdata: I_PWDATA};

  // Write strobe: taken in access phase, answer is zero wait
  logic wr_en;
  logic [7:0] wdat;
  assign wr_en = req.psel & req.penable & req.pwrite & I_CE;
  assign wdat = req.pwdata[7:0];

  // Known offsets
  logic addr_ok;
  always_comb begin
    unique case (req.paddr)
      OFS_EDGE_SEL, OFS_PRI_0, OFS_PRI_1, OFS_PRI_2, OFS_PRI_3,
      OFS_MF_0, OFS_MF_1, OFS_MF_2, OFS_MF_3, OFS_STATUS: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end

  // Edge-select register, one field per pin
  logic [7:0] edge_sel_q;
  logic [7:0] edge_mask;
  assign edge_mask = (NUM_PINS > 2) ? 8'hFF : 8'h0F;
  always_ff @(posedge I_CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      edge_sel_q <= RST_REG;
    end else if (wr_en && req.paddr == OFS_EDGE_SEL) begin
      edge_sel_q <= wdat & edge_mask;
    end
  end

  // Enable bits written by software
  logic global_irq_enable;
  logic [3:0] ext_pin_irq_enable;
  logic [1:0] comparator_irq_enable;
  logic converter_irq_enable;
  logic [3:0] multi_group_enable;
  logic [1:0] timebase_irq_enable;
  logic [3:0] mf_sub_en_q [4]; // Per-group sub-enables
  always_ff @(posedge I_CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      global_irq_enable <= 1'b0;
      ext_pin_irq_enable <= 4'h0;
      comparator_irq_enable <= 2'h0;
      converter_irq_enable <= 1'b0;
      multi_group_enable <= 4'h0;
      timebase_irq_enable <= 2'h0;
      for (int g = 0; g < 4; g++) begin
        mf_sub_en_q[g] <= 4'h0;
      end
    end else if (wr_en) begin
      // Primary registers 0..3 and group registers MF 0..3
      unique case (req.paddr)
        OFS_PRI_0: begin
          global_irq_enable <= wdat[POS_GLOBAL_EN];
          ext_pin_irq_enable[1:0] <= wdat[2:1];
          comparator_irq_enable[0] <= wdat[3];
        end
        OFS_PRI_1: begin
          comparator_irq_enable[1] <= wdat[0];
          multi_group_enable[1:0] <= wdat[2:1];
          converter_irq_enable <= wdat[3];
        end
        OFS_PRI_2: begin
          multi_group_enable[2] <= wdat[0];
          timebase_irq_enable <= wdat[2:1];
          multi_group_enable[3] <= wdat[3];
        end
        OFS_PRI_3: begin
          if (NUM_PINS > 2) begin
            ext_pin_irq_enable[3:2] <= wdat[1:0];
          end
        end
        OFS_MF_0: mf_sub_en_q[0] <= wdat[3:0];
        OFS_MF_1: mf_sub_en_q[1] <= {1'b0, wdat[2:0]}; // Group 1 has three sources only
        OFS_MF_2: mf_sub_en_q[2] <= wdat[3:0];
        OFS_MF_3: mf_sub_en_q[3] <= wdat[3:0];
        default: ;
      endcase
    end
  end

  // Flag write strobes per register
  logic [7:0] fwr;
  assign fwr = {2'b00,
                wr_en && req.paddr == OFS_MF_3, wr_en && req.paddr == OFS_MF_2,
                wr_en && req.paddr == OFS_MF_1, wr_en && req.paddr == OFS_MF_0,
                wr_en && req.paddr == OFS_PRI_3, wr_en && req.paddr == OFS_PRI_1};

  // External pin edge detection and flags
  logic [3:0] ext_pin_irq_flag;
  logic [3:0] pin_edge;
  genvar p;
  generate
    for (p = 0; p < 4; p++) begin : g_pin
      logic wr_pin;
      logic wv_pin;
      if (p < 2) begin : g_lo
        assign wr_pin = wr_en && req.paddr == OFS_PRI_0;
        assign wv_pin = wdat[4 + p];
      end else begin : g_hi
        // Pins beyond the variant keep their flags inert
        assign wr_pin = fwr[1] && (p < NUM_PINS);
        assign wv_pin = wdat[2 + p];
      end
      if (p < NUM_PINS) begin : g_on
        edge_detect u_edge (
          .i_clk(I_CORE_CLK),
          .i_rst_n(rst_n),
          .i_ce(I_CE),
          .i_pin(I_EXT_PIN[p]),
          .i_sel(edge_sel_q[2*p +: 2]),
          .o_edge(pin_edge[p])
        );
      end else begin : g_off
        assign pin_edge[p] = 1'b0;
      end
      flag_cell u_flag (
        .i_clk(I_CORE_CLK),
        .i_rst_n(rst_n),
        .i_ce(I_CE),
        .i_set(pin_edge[p]),
        .i_wr(wr_pin),
        .i_wval(wv_pin),
        .o_flag(ext_pin_irq_flag[p])
      );
    end
  endgenerate

  // Other primary flags, set by hardware, clearable by software
  logic [1:0] comparator_irq_flag;
  logic converter_irq_flag;
  logic [1:0] timebase_irq_flag;
  always_ff @(posedge I_CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      comparator_irq_flag <= 2'h0;
      converter_irq_flag <= 1'b0;
      timebase_irq_flag <= 2'h0;
    end else if (I_CE) begin
      // Event in same cycle as a write keeps the flag set
      comparator_irq_flag[0] <= I_CMP_EVT[0] |
        ((wr_en && req.paddr == OFS_PRI_0) ? wdat[6] : comparator_irq_flag[0]);
      comparator_irq_flag[1] <= I_CMP_EVT[1] |
        ((wr_en && req.paddr == OFS_PRI_1) ? wdat[4] : comparator_irq_flag[1]);
      converter_irq_flag <= I_CONV_EVT |
        ((wr_en && req.paddr == OFS_PRI_1) ? wdat[7] : converter_irq_flag);
      timebase_irq_flag <= I_TB_EVT |
        ((wr_en && req.paddr == OFS_PRI_2) ? wdat[6:5] : timebase_irq_flag);
    end
  end

  // Multi-function sub-flags: timers in groups 0,1,3; misc in group 2
  logic [3:0] mf_sub_set [4];
  logic [3:0] mf_sub_flag_q [4];
  assign mf_sub_set[0] = {I_TMR_CMP_A_EVT[2], I_TMR_PERIOD_EVT[2],
                          I_TMR_CMP_A_EVT[0], I_TMR_PERIOD_EVT[0]};
  assign mf_sub_set[1] = {1'b0, I_TMR_CMP_B_EVT[1], I_TMR_CMP_A_EVT[1],
                          I_TMR_PERIOD_EVT[1]};
  assign mf_sub_set[2] = {I_NVMEM_EVT, I_LOW_VOLT_EVT, I_PIN_CHANGE_EVT,
                          I_SERIAL_EVT};
  assign mf_sub_set[3] = {I_TMR_CMP_B_EVT[3], I_TMR_CMP_B_EVT[2],
                          I_TMR_CMP_A_EVT[3], I_TMR_PERIOD_EVT[3]};
  always_ff @(posedge I_CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      for (int g = 0; g < 4; g++) begin
        mf_sub_flag_q[g] <= 4'h0;
      end
    end else if (I_CE) begin
      for (int g = 0; g < 4; g++) begin
        mf_sub_flag_q[g] <= mf_sub_set[g] |
          (fwr[2 + g] ? (wdat[7:4] & ((g == 1) ? 4'h7 : 4'hF)) : mf_sub_flag_q[g]);
      end
    end
  end

  // Group flag is any sub-flag pending and enabled
  logic [3:0] multi_group_flag;
  always_comb begin
    for (int g = 0; g < 4; g++) begin
      multi_group_flag[g] = |(mf_sub_flag_q[g] & mf_sub_en_q[g]);
    end
  end

  // Interrupt request: flag, own enable and global enable
  logic irq_any;
  assign irq_any = global_irq_enable &
    (|(ext_pin_irq_flag & ext_pin_irq_enable) |
     |(comparator_irq_flag & comparator_irq_enable) |
     (converter_irq_flag & converter_irq_enable) |
     |(multi_group_flag & multi_group_enable) |
     |(timebase_irq_flag & timebase_irq_enable));

  // Read data mux
  logic [7:0] rd_val;
  always_comb begin
    rd_val = 8'h00;
    unique case (req.paddr)
      OFS_EDGE_SEL: rd_val = edge_sel_q;
      OFS_PRI_0: rd_val = {1'b0, comparator_irq_flag[0], ext_pin_irq_flag[1:0],
                           comparator_irq_enable[0], ext_pin_irq_enable[1:0],
                           global_irq_enable};
      OFS_PRI_1: rd_val = {converter_irq_flag, multi_group_flag[1:0],
                           comparator_irq_flag[1], converter_irq_enable,
                           multi_group_enable[1:0], comparator_irq_enable[1]};
      OFS_PRI_2: rd_val = {multi_group_flag[3], timebase_irq_flag,
                           multi_group_flag[2], multi_group_enable[3],
                           timebase_irq_enable, multi_group_enable[2]};
      OFS_PRI_3: rd_val = {2'b00, ext_pin_irq_flag[3:2], 2'b00,
                           ext_pin_irq_enable[3:2]};
      OFS_MF_0: rd_val = {mf_sub_flag_q[0], mf_sub_en_q[0]};
      OFS_MF_1: rd_val = {mf_sub_flag_q[1], mf_sub_en_q[1]};
      OFS_MF_2: rd_val = {mf_sub_flag_q[2], mf_sub_en_q[2]};
      OFS_MF_3: rd_val = {mf_sub_flag_q[3], mf_sub_en_q[3]};
      OFS_STATUS: rd_val = {7'h00, irq_any};
      default: rd_val = 8'h00;
    endcase
  end

  // Registered bus answer: ready in the first cycle of access phase
  always_ff @(posedge I_CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      O_PRDATA <= 32'h00000000;
      O_PREADY <= 1'b0;
      O_PSLVERR <= 1'b0;
    end else if (I_CE) begin
      O_PREADY <= req.psel & ~req.penable;
      O_PSLVERR <= req.psel & ~req.penable & ~addr_ok;
      if (req.psel & ~req.penable & ~req.pwrite) begin
        O_PRDATA <= {24'h000000, rd_val};
      end
    end
  end

  // Interrupt output register
  always_ff @(posedge I_CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      O_IRQ <= 1'b0;
    end else if (I_CE) begin
      O_IRQ <= irq_any;
    end
  end

endmodule

// file: irq_flag_ctrl_props.sv
`timescale 1ns/1ps
// Bus answer and interrupt output checks on the top ports
module irq_flag_ctrl_props
  import irq_ctrl_pkg::*;
(
  input wire logic I_CORE_CLK,
  input wire logic I_RESET_N,
  input wire logic I_CE,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [7:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  input wire logic [31:0] O_PRDATA,
  input wire logic O_PREADY,
  input wire logic O_PSLVERR,
  input wire logic O_IRQ
);
  default clocking cb @(posedge I_CORE_CLK);
  endclocking
  default disable iff (!I_RESET_N);
  // Setup phase seen by the slave
  sequence setup_s;
    I_PSEL && !I_PENABLE && I_CE;
  endsequence
  // Completed write that clears the global enable
  sequence global_off_s;
    I_PSEL && I_PENABLE && O_PREADY && I_CE && I_PWRITE && I_PADDR == OFS_PRI_0
      && !I_PWDATA[POS_GLOBAL_EN];
  endsequence
  ready_setup_a: assert property (setup_s |=> O_PREADY)
    else $error("ready missing after setup");
  ready_pulse_a: assert property (O_PREADY |=> !O_PREADY)
    else $error("ready longer than one cycle");
  ready_idle_a: assert property (!I_PSEL |=> !O_PREADY)
    else $error("ready without a transfer");
  err_unmapped_a: assert property ((setup_s ##0 I_PADDR > OFS_STATUS) |=> O_PSLVERR)
    else $error("no error for unmapped address");
  err_mapped_a: assert property ((setup_s ##0 I_PADDR <= OFS_STATUS && I_PADDR[1:0] == 2'h0)
    |=> !O_PSLVERR)
    else $error("error for mapped address");
  err_zero_a: assert property (O_PSLVERR && !I_PWRITE |-> O_PRDATA == 32'h0)
    else $error("unmapped read not zero");
  data_upper_a: assert property (O_PREADY && !I_PWRITE |-> O_PRDATA[31:8] == 24'h0)
    else $error("read data upper bits set");
  data_hold_a: assert property (!(I_PSEL && !I_PENABLE && !I_PWRITE) |=> $stable(O_PRDATA))
    else $error("read data moved without a read");
  global_off_a: assert property (global_off_s ##1 I_CE |=> !O_IRQ)
    else $error("interrupt with global enable off");
endmodule
bind irq_flag_ctrl irq_flag_ctrl_props props (.*);

// file: irq_flag_ctrl_test.sv
`timescale 1ns/1ps
module irq_flag_ctrl_test;
  import irq_ctrl_pkg::*;
  // One register: address, value written, value read back, error flag
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wval;
    logic [7:0] rval;
    logic err;
  } row_type;
  logic I_CORE_CLK, I_RESET_N, I_CE, I_PSEL, I_PENABLE, I_PWRITE;
  logic [7:0] I_PADDR;
  logic [31:0] I_PWDATA, O_PRDATA, prdata_two, rd;
  logic O_PREADY, O_PSLVERR, O_IRQ, er;
  logic [3:0] I_EXT_PIN, I_TMR_PERIOD_EVT, I_TMR_CMP_A_EVT, I_TMR_CMP_B_EVT;
  logic [1:0] I_CMP_EVT, I_TB_EVT;
  logic I_CONV_EVT, I_SERIAL_EVT, I_LOW_VOLT_EVT, I_NVMEM_EVT, I_PIN_CHANGE_EVT;
  int n_errors = 0;
  int checks = 0;
  int cycles = 0;
  // Register map with read-only and unused bits masked out
  row_type rows [10] = '{'{OFS_EDGE_SEL, 8'hFF, 8'hFF, 1'b0}, '{OFS_PRI_0, 8'hFF, 8'h7F, 1'b0},
    '{OFS_PRI_1, 8'hFF, 8'h9F, 1'b0}, '{OFS_PRI_2, 8'hFF, 8'h6F, 1'b0},
    '{OFS_PRI_3, 8'hFF, 8'h33, 1'b0}, '{OFS_MF_0, 8'hFF, 8'hFF, 1'b0},
    '{OFS_MF_1, 8'hFF, 8'h77, 1'b0}, '{OFS_MF_2, 8'hFF, 8'hFF, 1'b0},
    '{OFS_MF_3, 8'hFF, 8'hFF, 1'b0}, '{8'h28, 8'hFF, 8'h00, 1'b1}};
  // Flags after every event input pulses once
  logic [7:0] ev_exp [9] = '{8'h00, 8'h40, 8'h90, 8'h60, 8'h00, 8'hF0, 8'h70, 8'hF0, 8'hF0};
  // Control writes and the interrupt level they should give
  logic [7:0] irq_w [5] = '{8'h48, 8'h49, 8'h48, 8'h49, 8'h09};
  logic irq_e [5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
  irq_flag_ctrl #(.NUM_PINS(4)) DUT (.*);
  // Two-pin variant on the same bus
  irq_flag_ctrl #(.NUM_PINS(2)) DUT_TWO (.*, .O_PRDATA(prdata_two), .O_PREADY(), .O_PSLVERR(),
    .O_IRQ());
  // Clock of 10 ns
  initial begin
    I_CORE_CLK = 1'b0;
    forever #5 I_CORE_CLK = ~I_CORE_CLK;
  end
  // Hang guard
  always @(posedge I_CORE_CLK) begin
    cycles++;
    if (cycles == 10000) begin
      n_errors++;
      finish_test();
    end
  end
  // Compare and count
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One APB transfer, idle cycle before it
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge I_CORE_CLK);
    I_PSEL <= 1'b1;
    I_PWRITE <= w;
    I_PADDR <= a;
    I_PWDATA <= {24'h0, d};
    @(posedge I_CORE_CLK);
    I_PENABLE <= 1'b1;
    @(posedge I_CORE_CLK);
    while (O_PREADY !== 1'b1) @(posedge I_CORE_CLK);
    rd = O_PRDATA;
    er = O_PSLVERR;
    I_PSEL <= 1'b0;
    I_PENABLE <= 1'b0;
  endtask
  // Read and compare one register
  task automatic rdchk(input string what, input logic [7:0] a, input logic [7:0] exp);
    apb(1'b0, a, 8'h00);
    chk(what, rd, {24'h0, exp});
  endtask
  // Drive every event input to one level
  task automatic ev(input logic v);
    I_CMP_EVT <= {2{v}};
    I_CONV_EVT <= v;
    I_TB_EVT <= {2{v}};
    I_SERIAL_EVT <= v;
    I_LOW_VOLT_EVT <= v;
    I_NVMEM_EVT <= v;
    I_PIN_CHANGE_EVT <= v;
    I_TMR_PERIOD_EVT <= {4{v}};
    I_TMR_CMP_A_EVT <= {4{v}};
    I_TMR_CMP_B_EVT <= {4{v}};
  endtask
  // Counts and verdict
  task automatic finish_test();
    $display("Checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    I_RESET_N = 1'b0;
    I_CE = 1'b1;
    I_PSEL = 1'b0;
    I_PENABLE = 1'b0;
    I_PWRITE = 1'b0;
    I_PADDR = 8'h00;
    I_PWDATA = 32'h0;
    I_EXT_PIN = 4'h0;
    ev(1'b0);
    repeat (2) @(posedge I_CORE_CLK);
    I_RESET_N <= 1'b1;
    repeat (4) @(posedge I_CORE_CLK);
    // Reset value, write, read back, error answer
    foreach (rows[i]) begin
      rdchk("reset value", rows[i].addr, 8'h00);
      apb(1'b1, rows[i].addr, rows[i].wval);
      rdchk("readback", rows[i].addr, rows[i].rval);
      chk("error", 32'(er), 32'(rows[i].err));
    end
    rdchk("group flags", OFS_PRI_1, 8'hFF);
    rdchk("edge select", OFS_EDGE_SEL, 8'hFF);
    chk("narrow edge select", prdata_two, 32'h0F);
    foreach (rows[i]) apb(1'b1, rows[i].addr, 8'h00);
    $display("Register map test done");
    // Every pin, every code, both edges
    for (int p = 0; p < 4; p++) begin
      for (int c = 0; c < 4; c++) begin
        for (int e = 0; e < 2; e++) begin
          apb(1'b1, OFS_EDGE_SEL, 8'(c << (2 * p)));
          apb(1'b1, OFS_PRI_0, 8'h00);
          apb(1'b1, OFS_PRI_3, 8'h00);
          I_EXT_PIN[p] <= (e == 0);
          repeat (6) @(posedge I_CORE_CLK);
          rdchk("pin flag", p < 2 ? OFS_PRI_0 : OFS_PRI_3,
            ((c >> e) & 1) ? 8'(8'h10 << (p % 2)) : 8'h00);
        end
      end
    end
    $display("Edge select test done");
    // Leave no edge code or pin flag behind for the event test
    apb(1'b1, OFS_EDGE_SEL, 8'h00);
    apb(1'b1, OFS_PRI_3, 8'h00);
    @(posedge I_CORE_CLK);
    ev(1'b1);
    @(posedge I_CORE_CLK);
    ev(1'b0);
    for (int i = 0; i < 9; i++) rdchk("event flag", rows[i].addr, ev_exp[i]);
    apb(1'b1, OFS_MF_1, 8'h74);
    rdchk("group set", OFS_PRI_1, 8'hD0);
    apb(1'b1, OFS_MF_1, 8'h34);
    rdchk("group clear", OFS_PRI_1, 8'h90);
    $display("Event test done");
    // Gating by global enable and flag clear, source enable held on
    for (int i = 0; i < 5; i++) begin
      apb(1'b1, OFS_PRI_0, irq_w[i]);
      repeat (3) @(posedge I_CORE_CLK);
      chk("interrupt", 32'(O_IRQ), 32'(irq_e[i]));
      rdchk("status", OFS_STATUS, 8'(irq_e[i]));
    end
    $display("Interrupt gating test done");
    // Clock enable low freezes flags against events
    I_CE <= 1'b0;
    ev(1'b1);
    @(posedge I_CORE_CLK);
    ev(1'b0);
    I_CE <= 1'b1;
    rdchk("frozen flag", OFS_PRI_0, 8'h09);
    $display("Clock enable test done");
    // Reset in mid-run clears enables and the interrupt output
    apb(1'b1, OFS_PRI_0, 8'h49);
    repeat (2) @(posedge I_CORE_CLK);
    chk("irq before reset", 32'(O_IRQ), 32'h1);
    I_RESET_N <= 1'b0;
    repeat (2) @(posedge I_CORE_CLK);
    chk("irq in reset", 32'(O_IRQ), 32'h0);
    I_RESET_N <= 1'b1;
    repeat (4) @(posedge I_CORE_CLK);
    rdchk("reset clears", OFS_PRI_0, 8'h00);
    chk("irq after reset", 32'(O_IRQ), 32'h0);
    $display("Reset test done");
    finish_test();
  end
endmodule
